// [rtl/atc_ctrl.sv]
// antialias filter cutoff selection and capacitor tuning control
`timescale 1ns/1ps
module atc_ctrl #(
   parameter int TUNE_LEN = atc_pkg::TUNE_CYCLES,   // sample cycles per run
   parameter int TRIM_W = atc_pkg::TRIM_W           // trim code width
) (
   input wire logic clk_sys_i,                        // system clock, 100 MHz
   input wire logic rst_n_i,                          // async reset, active low
   input wire logic ce_i,                             // clock enable
   input wire logic reg_wr_i,                         // control port write strobe
   input wire logic reg_rd_i,                         // control port read strobe
   input wire logic [atc_pkg::ADDR_W-1:0] reg_addr_i, // control port address
   input wire logic [atc_pkg::DATA_W-1:0] reg_wdata_i,// control port write data
   output logic [atc_pkg::DATA_W-1:0] reg_rdata_o,    // read data
   output logic reg_rvalid_o,                         // read data valid pulse
   input wire logic sample_clk_i,                     // converter sample clock
   input wire logic [TRIM_W-1:0] trim_code_i,         // trim code from analog tuner
   output logic [1:0] lp_base_sel_o,                  // base fraction code
   output logic [2:0] lp_scale_sel_o,                 // scale code
   output logic [3:0] lp_div_x2_o,                    // base divisor times two
   output logic [7:0] lp_scale_pct_o,                 // scale in hundredths
   output logic cut_code_ok_o,                        // cutoff code is a legal one
   output logic [1:0] hp_ratio_sel_o,                 // highpass ratio code
   output logic [3:0] hp_ratio_o,                     // lowpass over highpass ratio
   output logic tune_en_o,                            // tuning circuit enable
   output logic [TRIM_W-1:0] cap_trim_o               // held capacitor trim code
);
   // base fraction code to divisor; zero marks the unused code
   function automatic logic [3:0] base_div(input logic [1:0] code);
      unique case (code)
         atc_pkg::BASE_THIRD: base_div = atc_pkg::DIV_X2_THIRD;
         atc_pkg::BASE_FOURHALF: base_div = atc_pkg::DIV_X2_FOURHALF;
         atc_pkg::BASE_SIXTH: base_div = atc_pkg::DIV_X2_SIXTH;
         default: base_div = 4'h0;
      endcase
   endfunction

   // scale code to hundredths; code 111 has no factor
   function automatic logic [7:0] scale_pct(input logic [2:0] code);
      unique case (code)
         3'h0: scale_pct = atc_pkg::SCALE_145;
         3'h1: scale_pct = atc_pkg::SCALE_125;
         3'h2: scale_pct = atc_pkg::SCALE_113;
         3'h3: scale_pct = atc_pkg::SCALE_100;
         3'h4: scale_pct = atc_pkg::SCALE_090;
         3'h5: scale_pct = atc_pkg::SCALE_080;
         3'h6: scale_pct = atc_pkg::SCALE_075;
         default: scale_pct = 8'h00;
      endcase
   endfunction

   // reset release through two flops; assertion is still immediate
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // pin synchronisers; the sample clock must stay below half of clk_sys
   // or edges are missed, so this suits the slower sample rates only
   logic [2:0] samp_q;                 // [0] first stage, [1] second, [2] edge delay
   logic [TRIM_W-1:0] trim_s1_q;       // first stage of trim code
   logic [TRIM_W-1:0] trim_s2_q;       // second stage, code is static at run end
   logic samp_edge;
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         samp_q <= 3'h0;
         trim_s1_q <= '0;
         trim_s2_q <= '0;
      end else if (ce_i) begin
         samp_q <= {samp_q[1:0], sample_clk_i};
         trim_s1_q <= trim_code_i;
         trim_s2_q <= trim_s1_q;
      end
   end
   assign samp_edge = samp_q[1] & ~samp_q[2];

   atc_tune_if #(.TRIM_W(TRIM_W)) tif ();

   // register state
   logic [7:0] cut_q, cut_d;           // cutoff select register
   logic [1:0] hp_q, hp_d;             // highpass ratio field
   logic tune_req_q, tune_req_d;       // tune bit as seen by software
   logic start_q, start_d;             // start pulse to the sequencer
   logic [7:0] rdata_q, rdata_d;       // read data
   logic rvalid_q, rvalid_d;           // read valid
   logic wr_cut, wr_hp;                // decoded writes
   logic tune_wr;                      // write with the tune bit set

   assign wr_cut = reg_wr_i && (reg_addr_i == atc_pkg::REG_LP_CUT);
   assign wr_hp = reg_wr_i && (reg_addr_i == atc_pkg::REG_HP_TUNE);
   assign tune_wr = wr_hp && reg_wdata_i[atc_pkg::TUNE_BIT];

   // next register values; a new start in the end cycle keeps the bit set
   always_comb begin
      cut_d = cut_q;
      hp_d = hp_q;
      tune_req_d = tune_req_q;
      start_d = tune_wr;
      rdata_d = rdata_q;
      rvalid_d = reg_rd_i;
      if (wr_cut) begin
         cut_d = reg_wdata_i & 8'hf8;                      // low bits reserved
      end
      if (wr_hp) begin
         hp_d = reg_wdata_i[atc_pkg::HP_RATIO_LSB +: 2];
      end
      if (tune_wr) begin
         tune_req_d = 1'b1;                                // set wins over clear
      end else if (tif.done) begin
         tune_req_d = 1'b0;                                // self-clear at run end
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            atc_pkg::REG_LP_CUT: rdata_d = cut_q;
            atc_pkg::REG_HP_TUNE: rdata_d = {1'b0, tune_req_q, 4'h0, hp_q};
            default: rdata_d = 8'h00;                      // unmapped reads zero
         endcase
      end
   end

   // register update
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         cut_q <= atc_pkg::LP_CUT_RST;
         hp_q <= atc_pkg::HP_TUNE_RST[1:0];
         tune_req_q <= 1'b0;                               // tuning idle
         start_q <= 1'b0;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else if (ce_i) begin
         cut_q <= cut_d;
         hp_q <= hp_d;
         tune_req_q <= tune_req_d;
         start_q <= start_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end
   assign tif.start = start_q;

   atc_tune_seq #(.TUNE_LEN(TUNE_LEN), .TRIM_W(TRIM_W)) u_seq (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .samp_edge_i(samp_edge),
      .trim_in_i(trim_s2_q),
      .tif(tif)
   );

   // decoded settings, registered so every output leaves a flop
   logic [1:0] base_q;
   logic [2:0] scale_q;
   logic [3:0] div_q;
   logic [7:0] pct_q;
   logic ok_q;
   logic [1:0] hps_q;
   logic [3:0] ratio_q;
   logic [3:0] ratio_d;
   logic ok_d;
   logic [1:0] cb;
   logic [2:0] cs;
   logic tune_q;
   logic [TRIM_W-1:0] ctrim_q;

   // field split and ratio lookup
   always_comb begin
      cb = cut_q[atc_pkg::CUT_BASE_LSB +: 2];               // upper two bits
      cs = cut_q[atc_pkg::CUT_SCALE_LSB +: 3];              // middle three bits, 5:3
      ok_d = (base_div(cb) != 4'h0) && (scale_pct(cs) != 8'h00);
      unique case (hp_q)
         2'h0: ratio_d = atc_pkg::HP_RATIO_12;              // default
         2'h1: ratio_d = atc_pkg::HP_RATIO_9;
         2'h2: ratio_d = atc_pkg::HP_RATIO_6;
         2'h3: ratio_d = atc_pkg::HP_RATIO_3;
      endcase
   end

   // output registers
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         base_q <= 2'h0;
         scale_q <= 3'h0;
         div_q <= 4'h0;
         pct_q <= 8'h00;
         ok_q <= 1'b0;
         hps_q <= 2'h0;
         ratio_q <= 4'h0;
         tune_q <= 1'b0;
         ctrim_q <= '0;
      end else if (ce_i) begin
         base_q <= cb;
         scale_q <= cs;
         div_q <= base_div(cb);
         pct_q <= scale_pct(cs);
         ok_q <= ok_d;
         hps_q <= hp_q;
         ratio_q <= ratio_d;
         tune_q <= tif.busy;
         ctrim_q <= tif.trim;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign lp_base_sel_o = base_q;
   assign lp_scale_sel_o = scale_q;
   assign lp_div_x2_o = div_q;
   assign lp_scale_pct_o = pct_q;
   assign cut_code_ok_o = ok_q;
   assign hp_ratio_sel_o = hps_q;
   assign hp_ratio_o = ratio_q;
   assign tune_en_o = tune_q;
   assign cap_trim_o = ctrim_q;

   default clocking dcb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   tune_start_a: assert property (ce_i && tune_wr |=> tune_req_q ##1 tif.busy)
      else $error("tune write did not start a run");
   ratio_map_a: assert property (ce_i && hp_q == 2'h1 |=> hp_ratio_o == 4'h9)
      else $error("highpass ratio code 01 not mapped to 9");
   ratio_sel_a: assert property (ce_i |=> hp_ratio_sel_o == $past(hp_q))
      else $error("highpass ratio code not passed on");
   base_div_a: assert property (cut_code_ok_o && lp_base_sel_o == 2'h1
      |-> lp_div_x2_o == 4'h9)
      else $error("fs/4.5 base not decoded");
   scale_end_a: assert property (cut_code_ok_o && lp_scale_sel_o == 3'h6
      |-> lp_scale_pct_o == 8'h4b)
      else $error("scale code 110 not 0.75");
   field_split_a: assert property (ce_i |=> lp_base_sel_o == $past(cut_q[7:6]))
      else $error("base fraction not taken from upper bits");
   idle_off_a: assert property (!tune_req_q |-> !tif.busy)
      else $error("tuning active without a request");
   self_clear_a: assert property ($fell(tune_req_q) |-> $past(tif.done))
      else $error("tune bit cleared without a run end");
endmodule

// [include/atc_pkg.sv]
// shared constants for the antialias filter cutoff and tuning control
package atc_pkg;
   localparam int ADDR_W = 12;                        // control port address width
   localparam int DATA_W = 8;                         // control port data width
   localparam logic [11:0] REG_LP_CUT = 12'h00f;      // filter_lowpass_cutoff_select
   localparam logic [11:0] REG_HP_TUNE = 12'h02b;     // filter_highpass_and_tune_control
   localparam logic [7:0] LP_CUT_RST = 8'h00;         // reset value of cutoff register
   localparam logic [7:0] HP_TUNE_RST = 8'h00;        // reset value of control register
   localparam int CUT_BASE_LSB = 6;                   // base fraction field, bits 7:6
   localparam int CUT_SCALE_LSB = 3;                  // scale field, bits 5:3
   localparam int HP_RATIO_LSB = 0;                   // high-pass ratio field, bits 1:0
   localparam int TUNE_BIT = 6;                       // tuning start / busy bit
   localparam int TUNE_CYCLES = 512;                  // sample clock cycles per tuning run
   localparam int TRIM_W = 8;                         // width of the capacitor trim code
   localparam logic [1:0] BASE_THIRD = 2'h0;          // fs / 3
   localparam logic [1:0] BASE_FOURHALF = 2'h1;       // fs / 4.5
   localparam logic [1:0] BASE_SIXTH = 2'h2;          // fs / 6
   localparam logic [3:0] DIV_X2_THIRD = 4'h6;        // divisor times two
   localparam logic [3:0] DIV_X2_FOURHALF = 4'h9;
   localparam logic [3:0] DIV_X2_SIXTH = 4'hc;
   localparam logic [7:0] SCALE_145 = 8'h91;          // scale in hundredths, code 000
   localparam logic [7:0] SCALE_125 = 8'h7d;
   localparam logic [7:0] SCALE_113 = 8'h71;
   localparam logic [7:0] SCALE_100 = 8'h64;
   localparam logic [7:0] SCALE_090 = 8'h5a;
   localparam logic [7:0] SCALE_080 = 8'h50;
   localparam logic [7:0] SCALE_075 = 8'h4b;          // code 110
   localparam logic [3:0] HP_RATIO_12 = 4'hc;         // lowpass over highpass, code 00
   localparam logic [3:0] HP_RATIO_9 = 4'h9;
   localparam logic [3:0] HP_RATIO_6 = 4'h6;
   localparam logic [3:0] HP_RATIO_3 = 4'h3;          // code 11
endpackage

// [include/atc_tune_if.sv]
// handshake between register front end and tuning sequencer
`timescale 1ns/1ps
interface atc_tune_if #(parameter int TRIM_W = 8);
   logic start;                // one-cycle request to begin or restart a run
   logic busy;                 // tuning circuit enabled
   logic done;                 // one-cycle pulse on the cycle the run ends
   logic [TRIM_W-1:0] trim;    // held capacitor trim code
   modport ctrl (output start, input busy, input done, input trim);
   modport seq (input start, output busy, output done, output trim);
endinterface

// [rtl/atc_tune_seq.sv]
// tuning run sequencer: counts sample clock edges and captures the trim
`timescale 1ns/1ps
module atc_tune_seq #(
   parameter int TUNE_LEN = atc_pkg::TUNE_CYCLES,
   parameter int TRIM_W = atc_pkg::TRIM_W
) (
   input wire logic clk_sys_i,               // system clock
   input wire logic rst_n_i,                 // synchronised reset, active low
   input wire logic ce_i,                    // clock enable
   input wire logic samp_edge_i,             // one pulse per sample clock rising edge
   input wire logic [TRIM_W-1:0] trim_in_i,  // synchronised trim code from analog loop
   atc_tune_if.seq tif                       // link to the register front end
);
   typedef enum logic {ATC_IDLE, ATC_RUN} atc_state_e;
   localparam int CNT_W = $clog2(TUNE_LEN + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TUNE_LEN - 1);

   atc_state_e state_q, state_d;            // run state
   logic [CNT_W-1:0] cnt_q, cnt_d;          // sample edges seen this run
   logic [TRIM_W-1:0] trim_q, trim_d;       // held trim code
   logic done_w;                            // last edge of the run

   // the run ends on its final sample edge; a new start in that cycle restarts it
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      trim_d = trim_q;
      done_w = (state_q == ATC_RUN) && samp_edge_i && (cnt_q == LAST);
      if (tif.start) begin                 // restart beats the natural end
         state_d = ATC_RUN;
         cnt_d = '0;
      end else if (state_q == ATC_RUN && samp_edge_i) begin
         if (done_w) begin                  // turn tuning off by itself
            state_d = ATC_IDLE;
            trim_d = trim_in_i;             // keep the new code until the next run ends
         end else begin
            cnt_d = cnt_q + 1'b1;           // count sample clock cycles
         end
      end
   end

   // registers only; ce low freezes the run
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ATC_IDLE;               // tuning off by default
         cnt_q <= '0;
         trim_q <= '0;
      end else if (ce_i) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         trim_q <= trim_d;
      end
   end

   assign tif.busy = (state_q == ATC_RUN);
   assign tif.done = done_w && ce_i && !tif.start;
   assign tif.trim = trim_q;

   // helper: sample edges since the start, for the run length check
   logic [CNT_W:0] hlp_q;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hlp_q <= '0;
      end else if (ce_i) begin
         if (tif.start) begin
            hlp_q <= '0;
         end else if (tif.busy && samp_edge_i) begin
            hlp_q <= hlp_q + 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   run_length_a: assert property ($fell(tif.busy) |-> hlp_q == (CNT_W+1)'(TUNE_LEN))
      else $error("tuning run did not last the set number of sample cycles");
   trim_hold_a: assert property (!tif.done |=> $stable(tif.trim))
      else $error("trim code changed outside a run end");
endmodule

// [bench/atc_ctrl_tb.sv]
// self-checking bench for the antialias filter cutoff and tuning control
`timescale 1ns/1ps
module atc_ctrl_tb;
   localparam int TLEN = 8;              // shortened run length keeps the sim brief
   logic clk_sys_i;                      // system clock
   logic rst_n_i;                        // reset, active low
   logic ce_i;                           // clock enable
   logic reg_wr_i;                       // write strobe
   logic reg_rd_i;                       // read strobe
   logic [11:0] reg_addr_i;              // register address
   logic [7:0] reg_wdata_i;              // write data
   logic [7:0] reg_rdata_o;              // read data
   logic reg_rvalid_o;                   // read data valid
   logic sample_clk_i;                   // converter sample clock, stands still when unused
   logic [7:0] trim_code_i;              // trim code from the analog tuner
   logic [1:0] lp_base_sel_o;            // base fraction code
   logic [2:0] lp_scale_sel_o;           // scale code
   logic [3:0] lp_div_x2_o;              // base divisor times two
   logic [7:0] lp_scale_pct_o;           // scale in hundredths
   logic cut_code_ok_o;                  // legal cutoff code
   logic [1:0] hp_ratio_sel_o;           // highpass ratio code
   logic [3:0] hp_ratio_o;               // lowpass over highpass ratio
   logic tune_en_o;                      // tuning circuit enable
   logic [7:0] cap_trim_o;               // held trim code
   int fail_count;                       // mismatches seen
   int checks_done;                      // comparisons made
   int n;                                // scratch wait count
   logic [3:0] div_tab [0:2] = '{4'h6, 4'h9, 4'hc};                          // 3, 4.5, 6
   logic [7:0] pct_tab [0:6] = '{8'h91, 8'h7d, 8'h71, 8'h64, 8'h5a, 8'h50, 8'h4b};
   logic [3:0] hp_tab [0:3] = '{4'hc, 4'h9, 4'h6, 4'h3};                    // 12, 9, 6, 3

   atc_ctrl #(.TUNE_LEN(TLEN), .TRIM_W(8)) DUT (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .sample_clk_i(sample_clk_i),
      .trim_code_i(trim_code_i), .lp_base_sel_o(lp_base_sel_o),
      .lp_scale_sel_o(lp_scale_sel_o), .lp_div_x2_o(lp_div_x2_o),
      .lp_scale_pct_o(lp_scale_pct_o), .cut_code_ok_o(cut_code_ok_o),
      .hp_ratio_sel_o(hp_ratio_sel_o), .hp_ratio_o(hp_ratio_o), .tune_en_o(tune_en_o),
      .cap_trim_o(cap_trim_o));

   // 100 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // verdict and end of run, the only exit point
   task end_sim;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // compare one value, four-state exact
   task chk(input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   // one register write, strobe held for a single edge
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask

   // read and compare; valid stands only in the cycle right after the taking edge
   task chk_rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(8'h01, {7'h00, reg_rvalid_o});
      chk(exp, reg_rdata_o);
   endtask

   // let registered outputs land after a write
   task settle;
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask

   // bounded wait for the tuning enable to reach a level
   task wait_en(input logic lvl, input int bound);
      n = 0;
      while (tune_en_o !== lvl) begin
         if (n == bound) begin
            fail_count++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, lvl, tune_en_o);
            end_sim;
         end
         @(posedge clk_sys_i);
         #1;
         n++;
      end
   endtask

   // sample clock rising edges, high and low three system cycles each
   task edges(input int cnt);
      repeat (cnt) begin
         @(posedge clk_sys_i) sample_clk_i <= 1'b1;
         repeat (3) @(posedge clk_sys_i);
         sample_clk_i <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
      end
      @(posedge clk_sys_i);
      #1;
   endtask

   // reset held eleven cycles, then past the two-flop release
   task do_reset;
      @(posedge clk_sys_i) rst_n_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      #1;
      chk(8'h00, {7'h00, tune_en_o});
      @(posedge clk_sys_i) rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask

   // defaults after reset: tuning off, ratio 12, fs/3 at 1.45
   task t_defaults;
      chk(8'h00, {7'h00, tune_en_o});
      chk(8'h0c, {4'h0, hp_ratio_o});
      chk(8'h06, {4'h0, lp_div_x2_o});
      chk(8'h91, lp_scale_pct_o);
      chk_rd(atc_pkg::REG_LP_CUT, atc_pkg::LP_CUT_RST);
      chk_rd(atc_pkg::REG_HP_TUNE, atc_pkg::HP_TUNE_RST);
   endtask

   // every base and scale code, low bits written as ones must read zero
   task t_cutoff;
      for (int b = 0; b < 4; b++) begin
         for (int s = 0; s < 8; s++) begin
            wr(atc_pkg::REG_LP_CUT, {b[1:0], s[2:0], 3'h7});
            settle;
            chk({6'h00, b[1:0]}, {6'h00, lp_base_sel_o});
            chk({5'h00, s[2:0]}, {5'h00, lp_scale_sel_o});
            chk((b < 3) ? {4'h0, div_tab[b]} : 8'h00, {4'h0, lp_div_x2_o});
            chk((s < 7) ? pct_tab[s] : 8'h00, lp_scale_pct_o);
            chk({7'h00, b < 3 && s < 7}, {7'h00, cut_code_ok_o});
            chk_rd(atc_pkg::REG_LP_CUT, {b[1:0], s[2:0], 3'h0});
         end
      end
   endtask

   // all ratio codes, reserved bits set, tune bit clear
   task t_hpass;
      for (int c = 0; c < 4; c++) begin
         wr(atc_pkg::REG_HP_TUNE, 8'hbc | c[7:0]);
         settle;
         chk({6'h00, c[1:0]}, {6'h00, hp_ratio_sel_o});
         chk({4'h0, hp_tab[c]}, {4'h0, hp_ratio_o});
         chk(8'h00, {7'h00, tune_en_o});
         chk_rd(atc_pkg::REG_HP_TUNE, {6'h00, c[1:0]});
      end
   endtask

   // one full run: on within a few cycles, off after the last edge, trim captured
   task t_tune;
      @(posedge clk_sys_i) trim_code_i <= 8'h5a;
      wr(atc_pkg::REG_HP_TUNE, 8'h42);
      wait_en(1'b1, 4);
      chk(8'h06, {4'h0, hp_ratio_o});
      chk_rd(atc_pkg::REG_HP_TUNE, 8'h42);
      edges(TLEN - 1);
      chk(8'h01, {7'h00, tune_en_o});
      edges(1);
      wait_en(1'b0, 8);
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk(8'h5a, cap_trim_o);
      chk_rd(atc_pkg::REG_HP_TUNE, 8'h02);
   endtask

   // rewrite mid-run restarts the count; old trim held until the new end
   task t_restart;
      wr(atc_pkg::REG_HP_TUNE, 8'h40);
      wait_en(1'b1, 4);
      @(posedge clk_sys_i) trim_code_i <= 8'ha5;
      edges(TLEN - 2);
      wr(atc_pkg::REG_HP_TUNE, 8'h40);
      edges(TLEN - 1);
      chk(8'h01, {7'h00, tune_en_o});
      chk(8'h5a, cap_trim_o);
      edges(1);
      wait_en(1'b0, 8);
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk(8'ha5, cap_trim_o);
   endtask

   // unmapped writes vanish and read zero; disabled clock ignores strobes
   task t_unmapped;
      wr(atc_pkg::REG_LP_CUT, 8'h48);
      wr(12'h010, 8'hff);
      wr(12'h02c, 8'hff);
      chk_rd(12'h010, 8'h00);
      @(posedge clk_sys_i) ce_i <= 1'b0;
      wr(atc_pkg::REG_LP_CUT, 8'h90);
      @(posedge clk_sys_i) ce_i <= 1'b1;
      chk_rd(atc_pkg::REG_LP_CUT, 8'h48);
      chk_rd(atc_pkg::REG_HP_TUNE, 8'h00);
   endtask

   // main sequence, ends with a reset in the middle of a run
   initial begin
      fail_count = 0;
      checks_done = 0;
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 12'h000;
      reg_wdata_i = 8'h00;
      sample_clk_i = 1'b0;
      trim_code_i = 8'h00;
      do_reset;
      t_defaults;
      t_cutoff;
      t_hpass;
      t_tune;
      t_restart;
      t_unmapped;
      wr(atc_pkg::REG_HP_TUNE, 8'h40);
      wait_en(1'b1, 4);
      do_reset;
      t_defaults;
      end_sim;
   end
endmodule
